// File: core/vic_map.vh
// Constants for the vectored priority interrupt controller.
`ifndef VIC_MAP_VH
`define VIC_MAP_VH
`define VIC_NUM_SRC      32
`define VIC_ID_W         5
`define VIC_VEC_W        32
`define VIC_PRI_W        3
`define VIC_STACK_DEPTH  8
`define VIC_MODE_W       5
`define VIC_MODE_PRI_LSB 0
`define VIC_MODE_TYPE_LSB 3
`define VIC_TYPE_EDGE_BIT 3
`define VIC_TYPE_POL_BIT  4
`define VIC_FAST_SRC     0
`define VIC_SOFT_SRC     1
`define VIC_MODE_RESET   5'h00
`define VIC_VEC_RESET    32'h00000000
`define VIC_NO_LEVEL     4'h0
`endif

// File: core/vic_src_cell.v
// One interrupt source cell: sensitivity, pending latch, set and clear.
`timescale 1ns/10ps
`include "vic_map.vh"
module vic_src_cell #(
   parameter IS_EXTERNAL = 1'b0
) (
   // Clock and reset.
   input wire sys_clk,
   input wire rst_n,
   // Source and configuration.
   input wire src_in,
   input wire [1:0] sens,
   // Commands.
   input wire set_cmd,
   input wire clear_cmd,
   input wire ack,
   // Result.
   output wire active
);
   reg last_in;
   reg edge_pend;
   wire is_edge;
   wire polarity;
   wire level_now;
   wire edge_seen;

   // Internal sources always use high level or rising edge.
   // sensitivity field decode
   assign is_edge   = sens[0];
   assign polarity  = IS_EXTERNAL ? sens[1] : 1'b1;
   assign level_now = polarity ? src_in : ~src_in;
   assign edge_seen = level_now & ~(polarity ? last_in : ~last_in);

   // Edge pending flag; a fresh edge or set wins over clear and acknowledge.
   // software set and clear
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         last_in   <= 1'b0;
         edge_pend <= 1'b0;
      end else begin
         last_in <= src_in;
         if ((edge_seen | set_cmd) & is_edge)
            edge_pend <= 1'b1;
         else if (clear_cmd | ack | ~is_edge)
            edge_pend <= 1'b0;
      end
   end

   assign active = is_edge ? edge_pend : level_now;
endmodule

// File: core/vic_stack.v
// Last-in first-out stack of nested priority levels.
`timescale 1ns/10ps
`include "vic_map.vh"
module vic_stack #(
   parameter DEPTH = `VIC_STACK_DEPTH,
   parameter W     = 4
) (
   // Clock and reset.
   input wire sys_clk,
   input wire rst_n,
   // Push and pop.
   input wire push,
   input wire [W-1:0] push_data,
   input wire pop,
   // State.
   output wire [W-1:0] top,
   output wire empty
);
   reg [W-1:0] mem [0:DEPTH-1];
   reg [3:0]   count;
   integer     i;

   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         count <= 4'h0;
         for (i = 0; i < DEPTH; i = i + 1)
            mem[i] <= {W{1'b0}};
      end else if (push && count < DEPTH[3:0]) begin
         mem[count[2:0]] <= push_data;
         count           <= count + 4'h1;
      end else if (pop && count != 4'h0) begin
         count <= count - 4'h1;
      end
   end

   assign empty = (count == 4'h0);
   assign top   = empty ? {W{1'b0}} : mem[count[2:0] - 3'h1];
endmodule

// File: core/vic_core.v
// Vectored eight-level priority interrupt controller, top level.
//
// Behaviour
// - Vector read returns current source handler slot.
// - Each source has priority zero to seven.
// - Equal priority: lowest source number wins.
// - Vector read latches current priority level.
// - Newer higher interrupt before read is returned.
// - Higher after read reasserts; next read pushes.
// - End-of-service pops previous level from stack.
// - Normal read drops request, clears edge source.
// - Enable/disable commands build readable source mask.
// - Masked source is kept out of arbitration; its edge pending flag still latches.
// - Set/clear commands force edge pending state.
// - Only fast input drives fast request line.
// - Fast vector read returns fast slot.
// - Nothing pending on read gives spurious vector.
// - After a normal-mode spurious, requests stay low until end.
// - Protect mode follows external enable bit.
// - Protect mode: push and acknowledge on write.
// - Protect read leaves context and status unchanged.
// - Normal-mode vector write has no effect.
// - Sensitivity field selects level/edge, and polarity for external sources only.
// - Status reports current source number.
//
// Operation
// Every source owns a cell that turns its pin into an active flag.
// A level source follows its pin, after the polarity is applied.
// An edge source latches into a pending flag until it is acknowledged.
// Software set and clear strobes act on edge sources only.
// A level source ignores them, because its pin alone decides its state.
//
// The arbiter looks only at unmasked, active sources from 1 upward.
// Source 0 is the fast input and never takes part in priority.
// It raises the fast request line directly, gated by its mask bit.
//
// The current level is kept one above the priority in service.
// Zero therefore means that nothing is in service at all.
// This costs one extra bit but keeps level 0 sources servable.
// A winner raises the normal request only if it beats that level.
//
// A normal vector read commits the winner in the same cycle.
// The level in service, if any, is pushed before the new one is taken.
// A protect-mode read only memorises the winner and its priority.
// The following vector write then commits what was memorised.
// Extra reads between the two simply memorise the newest winner.
//
// A read with no higher winner returns the spurious vector.
// In normal mode it also enters the spurious state, which holds
// both request lines low until end of service is strobed.
// That strobe then leaves the level and the stack untouched.
// A fast vector read with the fast source idle behaves the same way.
//
// End of service pops the stack into the current level.
// With an empty stack the level falls back to zero, which is idle.
// Limitation: a push beyond the stack depth is dropped silently.
// With one entry per level that cannot happen, since each push
// needs a strictly higher level than the one in service.
//
// Hazard: mode and vector slots are not guarded against a write
// while their source is being served; software must avoid that.
`timescale 1ns/10ps
`include "vic_map.vh"
module vic_core #(
   parameter NSRC = `VIC_NUM_SRC,
   parameter EXT_MASK = 32'h3f000001
) (
   // Clock and reset.
   input wire sys_clk,
   input wire reset_n,
   // Sources; bit 0 is the fast interrupt input.
   input wire [NSRC-1:0] irq_src,
   // Configuration slot write and spurious vector.
   input wire cfg_wr,
   input wire [4:0] cfg_idx,
   input wire [`VIC_MODE_W-1:0] cfg_mode,
   input wire [`VIC_VEC_W-1:0] cfg_vector,
   input wire [`VIC_VEC_W-1:0] spurious_vector,
   // Command strobes, one bit per source, then the single end-of-service strobe.
   input wire [NSRC-1:0] source_enable_cmd,
   input wire [NSRC-1:0] source_disable_cmd,
   input wire [NSRC-1:0] source_set_cmd,
   input wire [NSRC-1:0] source_clear_cmd,
   input wire end_of_service_cmd,
   // Vector port strobes and protect mode enable.
   input wire irq_vector_rd,
   input wire irq_vector_wr,
   input wire fast_vector_rd,
   input wire protect_enable,
   // Processor request lines.
   output wire normal_request_line,
   output wire fast_request_line,
   // Read data.
   output reg [`VIC_VEC_W-1:0] irq_vector_port,
   output reg [`VIC_VEC_W-1:0] fast_vector_port,
   output reg [`VIC_ID_W-1:0] current_source_number,
   output reg [NSRC-1:0] source_mask_view,
   output wire [`VIC_PRI_W:0] current_level
);
   // ==========================================================
   // Reset release
   reg [1:0] rst_sync;
   wire      rst_n;

   // Asynchronous assert, two-flop synchronous release.
   always @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n)
         rst_sync <= 2'b00;
      else
         rst_sync <= {rst_sync[0], 1'b1};
   end
   assign rst_n = rst_sync[1];

   // ==========================================================
   // Configuration storage
   reg [`VIC_MODE_W-1:0] mode_slot [0:NSRC-1];
   reg [`VIC_VEC_W-1:0]  source_vector_slot [0:NSRC-1];
   integer k;

   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         for (k = 0; k < NSRC; k = k + 1) begin
            mode_slot[k]          <= `VIC_MODE_RESET;
            source_vector_slot[k] <= `VIC_VEC_RESET;
         end
      end else if (cfg_wr) begin
         mode_slot[cfg_idx]          <= cfg_mode;
         source_vector_slot[cfg_idx] <= cfg_vector;
      end
   end

   // Mask register; an enable in the same cycle as a disable wins.
   // enable and disable commands
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n)
         source_mask_view <= {NSRC{1'b0}};
      else
         source_mask_view <= (source_mask_view & ~source_disable_cmd) | source_enable_cmd;
   end

   // ==========================================================
   // Source cells
   wire [NSRC-1:0] active;
   reg  [NSRC-1:0] ack_vec;
   genvar g;
   generate
      for (g = 0; g < NSRC; g = g + 1) begin : cells
         vic_src_cell #(
            .IS_EXTERNAL (EXT_MASK[g])
         ) u_cell (
            .sys_clk   (sys_clk),
            .rst_n     (rst_n),
            .src_in    (irq_src[g]),
            .sens      (mode_slot[g][`VIC_TYPE_POL_BIT:`VIC_TYPE_EDGE_BIT]),
            .set_cmd   (source_set_cmd[g]),
            .clear_cmd (source_clear_cmd[g]),
            .ack       (ack_vec[g]),
            .active    (active[g])
         );
      end
   endgenerate

   // ==========================================================
   // Arbitration
   wire [NSRC-1:0] live;
   reg  [`VIC_ID_W-1:0]  win_id;
   reg  [`VIC_PRI_W-1:0] win_pri;
   reg                   win_any;
   reg  [`VIC_PRI_W-1:0] pri_k;
   integer j;

   assign live = active & source_mask_view;

   // Scan from the highest number down so ties resolve to the lowest.
   // priority encoder
   always @* begin
      win_id  = {`VIC_ID_W{1'b0}};
      win_pri = {`VIC_PRI_W{1'b0}};
      win_any = 1'b0;
      pri_k   = {`VIC_PRI_W{1'b0}};
      for (j = NSRC - 1; j >= 1; j = j - 1) begin
         pri_k = mode_slot[j][`VIC_PRI_W-1:0];
         if (live[j] && (!win_any || pri_k >= win_pri)) begin
            win_any = 1'b1;
            win_pri = pri_k;
            win_id  = j[`VIC_ID_W-1:0];
         end
      end
   end

   // ==========================================================
   // Context: current level (0 means idle, else priority+1) and stack
   reg  [`VIC_PRI_W:0] cur_level;
   reg                 spurious;
   reg                 memo_valid;
   reg  [`VIC_ID_W-1:0]  memo_id;
   reg  [`VIC_PRI_W-1:0] memo_pri;
   wire [`VIC_PRI_W:0] stack_top;
   wire                stack_empty;
   wire                higher;
   wire                take_rd;
   wire                commit;
   wire                eoi_pop;
   wire [`VIC_ID_W-1:0]  commit_id;
   wire [`VIC_PRI_W:0]   commit_lvl;

   // A winner counts only if it beats the level in service.
   assign higher  = win_any && ({1'b0, win_pri} + 4'h1 > cur_level);
   assign take_rd = irq_vector_rd & ~protect_enable;
   assign commit  = (take_rd & higher) | (irq_vector_wr & protect_enable & memo_valid);
   assign commit_id  = take_rd ? win_id : memo_id;
   assign commit_lvl = take_rd ? ({1'b0, win_pri} + 4'h1) : ({1'b0, memo_pri} + 4'h1);
   assign eoi_pop = end_of_service_cmd & ~spurious & ~stack_empty;

   vic_stack #(
      .DEPTH (`VIC_STACK_DEPTH),
      .W     (`VIC_PRI_W + 1)
   ) u_stack (
      .sys_clk   (sys_clk),
      .rst_n     (rst_n),
      .push      (commit && cur_level != `VIC_NO_LEVEL),
      .push_data (cur_level),
      .pop       (eoi_pop),
      .top       (stack_top),
      .empty     (stack_empty)
   );

   // Acknowledge clears the committed edge source.
   // clear edge on acknowledge
   always @* begin
      ack_vec = {NSRC{1'b0}};
      if (commit)
         ack_vec[commit_id] = 1'b1;
   end

   // Context update on read, protect write and end of service.
   // latch level on read
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         cur_level             <= `VIC_NO_LEVEL;
         spurious              <= 1'b0;
         memo_valid            <= 1'b0;
         memo_id               <= {`VIC_ID_W{1'b0}};
         memo_pri              <= {`VIC_PRI_W{1'b0}};
         current_source_number <= {`VIC_ID_W{1'b0}};
         irq_vector_port       <= `VIC_VEC_RESET;
      end else begin
         if (irq_vector_rd) begin
            irq_vector_port <= higher ? source_vector_slot[win_id] : spurious_vector;
            memo_valid      <= higher;
            memo_id         <= win_id;
            memo_pri        <= win_pri;
         end else if (irq_vector_wr & protect_enable) begin
            memo_valid <= 1'b0;
         end
         if (end_of_service_cmd)
            spurious <= 1'b0;
         else if (irq_vector_rd & ~higher & (~protect_enable | ~spurious))
            spurious <= ~protect_enable;
         else if (fast_vector_rd & ~live[`VIC_FAST_SRC] & ~protect_enable)
            spurious <= 1'b1;
         if (commit) begin
            cur_level             <= commit_lvl;
            current_source_number <= commit_id;
         end else if (end_of_service_cmd & ~spurious) begin
            cur_level <= stack_top;
         end
      end
   end

   // The read raises the level, so the request drops by itself until a
   // strictly higher source appears; no separate drop flag is needed.
   assign normal_request_line = higher & ~spurious;

   // ==========================================================
   // Fast path
   // fast input only
   assign fast_request_line = live[`VIC_FAST_SRC] & ~spurious;

   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n)
         fast_vector_port <= `VIC_VEC_RESET;
      else if (fast_vector_rd)
         fast_vector_port <= live[`VIC_FAST_SRC] ? source_vector_slot[`VIC_FAST_SRC]
                                                  : spurious_vector;
   end

   assign current_level = cur_level;
endmodule

// File: tb/vic_core_assertions.sv
// Port-level checks for the interrupt controller.
`timescale 1ns/10ps
module vic_core_assertions #(
   parameter NSRC = 32
) (
   // Clock, reset, strobes, protect mode and spurious vector.
   input wire            sys_clk,
   input wire            reset_n,
   input wire            irq_vector_rd,
   input wire            irq_vector_wr,
   input wire            end_of_service_cmd,
   input wire            protect_enable,
   input wire [31:0]     spurious_vector,
   // Outputs under watch.
   input wire            normal_request_line,
   input wire            fast_request_line,
   input wire [31:0]     irq_vector_port,
   input wire [NSRC-1:0] source_mask_view,
   input wire [3:0]      current_level
);
   // ==========================================
   // Checks
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!reset_n);
   // Reads split by mode, since only normal reads move the context.
   wire rd_n = irq_vector_rd & ~protect_enable;
   wire rd_p = irq_vector_rd & protect_enable & ~irq_vector_wr;
   fast_mask_a:
   assert property ($rose(fast_request_line) |-> source_mask_view[0])
      else $error("Fast request from a masked input.");
   irq_mask_a:
   assert property ($rose(normal_request_line) |-> |source_mask_view[NSRC-1:1])
      else $error("Normal request with all sources masked.");
   read_drop_a:
   assert property (rd_n |=> !normal_request_line)
      else $error("Request still high after a vector read.");
   read_up_a:
   assert property (rd_n && normal_request_line && !end_of_service_cmd
      |=> current_level > $past(current_level)) else $error("Level not raised.");
   eoi_pop_a:
   assert property (end_of_service_cmd && !irq_vector_rd && !irq_vector_wr
      |=> current_level < $past(current_level) || current_level == 4'h0)
      else $error("End of service did not restore a lower level.");
   wr_none_a:
   assert property (irq_vector_wr && !protect_enable && !irq_vector_rd
      && !end_of_service_cmd |=> $stable(current_level)) else $error("Write moved level.");
   prot_rd_a:
   assert property (rd_p && !end_of_service_cmd |=> $stable(current_level))
      else $error("Protect read alone moved the level.");
   spur_quiet_a:
   assert property ($past(rd_n) && irq_vector_port == spurious_vector
      |-> (!(normal_request_line || fast_request_line)) throughout
      (##[0:20] end_of_service_cmd)) else $error("Request during spurious state.");
endmodule
bind vic_core vic_core_assertions #(.NSRC(NSRC)) vic_core_assertions_inst (
   .sys_clk(sys_clk), .reset_n(reset_n), .irq_vector_rd(irq_vector_rd),
   .irq_vector_wr(irq_vector_wr), .end_of_service_cmd(end_of_service_cmd),
   .protect_enable(protect_enable), .spurious_vector(spurious_vector),
   .normal_request_line(normal_request_line), .fast_request_line(fast_request_line),
   .irq_vector_port(irq_vector_port), .source_mask_view(source_mask_view),
   .current_level(current_level)
);

// File: tb/vic_cpu_model.sv
// Processor-side model that fetches vectors and ends service.
`timescale 1ns/10ps
module vic_cpu_model (
   // Clock and orders from the bench.
   input wire        sys_clk,
   input wire        fetch_go,
   input wire        write_back,
   input wire        end_go,
   // Strobes toward the controller.
   output reg        vec_rd,
   output reg        vec_wr,
   output reg        eos,
   // Vector fetched.
   input wire [31:0] vec_in,
   output reg [31:0] vec_got
);
   reg got_now;
   // Quiet bus from time zero.
   initial begin
      {vec_rd, vec_wr, eos, got_now} = 4'h0;
      vec_got = 32'h0;
   end
   // fetch, write back, end
   // The write follows its own read only, so no stray write reaches the port.
   always @(posedge sys_clk) begin
      vec_rd <= fetch_go;
      vec_wr <= vec_rd & write_back;
      got_now <= vec_rd;
      eos <= end_go;
      if (got_now) begin
         vec_got <= vec_in;
      end
   end
endmodule

// File: tb/vic_core_test.sv
// Self-checking bench for the interrupt controller.
`timescale 1ns/10ps
module vic_core_test;
   // ==========================================
   // Signals
   reg         sys_clk, reset_n, cfg_wr, fast_rd, prot, go, wb, eg;
   reg  [31:0] src, en, dis, sc, cc, cfg_vec, spur;
   reg  [4:0]  cfg_idx, cfg_mode;
   wire        rd, wr, eos, nreq, freq;
   wire [31:0] ivec, fvec, mask, got;
   wire [4:0]  stat;
   wire [3:0]  lvl;
   integer     miscompares, num_checks;
   vic_core vic_core_inst (
      .sys_clk(sys_clk), .reset_n(reset_n), .irq_src(src), .cfg_wr(cfg_wr),
      .cfg_idx(cfg_idx), .cfg_mode(cfg_mode), .cfg_vector(cfg_vec),
      .spurious_vector(spur), .source_enable_cmd(en), .source_disable_cmd(dis),
      .source_set_cmd(sc), .source_clear_cmd(cc), .end_of_service_cmd(eos),
      .irq_vector_rd(rd), .irq_vector_wr(wr), .fast_vector_rd(fast_rd),
      .protect_enable(prot), .normal_request_line(nreq), .fast_request_line(freq),
      .irq_vector_port(ivec), .fast_vector_port(fvec),
      .current_source_number(stat), .source_mask_view(mask), .current_level(lvl)
   );
   vic_cpu_model vic_cpu_model_inst (
      .sys_clk(sys_clk), .fetch_go(go), .write_back(wb), .end_go(eg),
      .vec_rd(rd), .vec_wr(wr), .eos(eos), .vec_in(ivec), .vec_got(got)
   );
   // ==========================================
   // Helpers
   // Inputs always move 2 ns after an edge, clear of sampling.
   task tick(input integer n);
      begin
         repeat (n) @(posedge sys_clk);
         #2;
      end
   endtask
   task chk(input logic [31:0] a, input logic [31:0] e);
      begin
         num_checks = num_checks + 1;
         if (a !== e) begin
            miscompares = miscompares + 1;
            $display("Error at %0t: got %h, expected %h", $time, a, e);
         end
      end
   endtask
   task cfg(input [4:0] i, input [4:0] m, input [31:0] v);
      begin
         {cfg_idx, cfg_mode, cfg_vec, cfg_wr} = {i, m, v, 1'b1};
         tick(1);
         cfg_wr = 1'b0;
         tick(1);
      end
   endtask
   // Kind 0 enables, 1 disables, 2 sets, 3 clears.
   task cmd(input [1:0] k, input [31:0] b);
      begin
         en = (k == 2'h0) ? b : 32'h0;
         dis = (k == 2'h1) ? b : 32'h0;
         sc = (k == 2'h2) ? b : 32'h0;
         cc = (k == 2'h3) ? b : 32'h0;
         tick(1);
         {en, dis, sc, cc} = 128'h0;
         tick(1);
      end
   endtask
   task fetch(input w);
      begin
         {wb, go} = {w, 1'b1};
         tick(1);
         go = 1'b0;
         tick(3);
      end
   endtask
   task eoi;
      begin
         eg = 1'b1;
         tick(1);
         eg = 1'b0;
         tick(3);
      end
   endtask
   task complete_run;
      begin
         $display("Checks %0d, mismatches %0d", num_checks, miscompares);
         if (miscompares == 0 && num_checks > 0)
            $display("== PASSED ==");
         else
            $display("== FAILED ==");
         $finish;
      end
   endtask
   // ==========================================
   // Scenarios
   task t_prio;
      begin
         cfg(5'h2, 5'h1b, 32'h200);
         cfg(5'h3, 5'h1d, 32'h300);
         cfg(5'h4, 5'h1d, 32'h400);
         cmd(2'h0, 32'h1c);
         cmd(2'h2, 32'h1c);
         chk(nreq, 32'h1);
         fetch(1'b1);
         chk(got, 32'h300);
         chk(lvl, 32'h6);
         chk(stat, 32'h3);
         chk(nreq, 32'h0);
         eoi;
         fetch(1'b0);
         chk(got, 32'h400);
         eoi;
         fetch(1'b0);
         chk(got, 32'h200);
         eoi;
         chk(lvl, 32'h0);
         $display("t_prio done");
      end
   endtask
   task t_nest;
      begin
         cfg(5'h5, 5'h1e, 32'h500);
         cmd(2'h0, 32'h20);
         cmd(2'h2, 32'h4);
         cmd(2'h2, 32'h20);
         fetch(1'b0);
         chk(got, 32'h500);
         chk(lvl, 32'h7);
         eoi;
         fetch(1'b0);
         chk(lvl, 32'h4);
         cmd(2'h2, 32'h8);
         chk(nreq, 32'h1);
         fetch(1'b0);
         chk(got, 32'h300);
         eoi;
         chk(lvl, 32'h4);
         eoi;
         chk(lvl, 32'h0);
         $display("t_nest done");
      end
   endtask
   task t_prot;
      begin
         prot = 1'b1;
         cmd(2'h2, 32'h4);
         fetch(1'b0);
         chk(got, 32'h200);
         chk(lvl, 32'h0);
         chk(nreq, 32'h1);
         fetch(1'b1);
         chk(stat, 32'h2);
         chk(lvl, 32'h4);
         chk(nreq, 32'h0);
         eoi;
         prot = 1'b0;
         $display("t_prot done");
      end
   endtask
   task t_mask;
      begin
         cmd(2'h1, 32'h20);
         chk(mask, 32'h1c);
         cmd(2'h2, 32'h20);
         chk(nreq, 32'h0);
         fetch(1'b0);
         chk(got, 32'hbad0);
         cmd(2'h0, 32'h20);
         chk(nreq, 32'h0);
         eoi;
         chk(nreq, 32'h1);
         cmd(2'h3, 32'h20);
         chk(nreq, 32'h0);
         chk(mask, 32'h3c);
         $display("t_mask done");
      end
   endtask
   task t_fast;
      begin
         cfg(5'h0, 5'h10, 32'hf00);
         cmd(2'h0, 32'h1);
         src[0] = 1'b1;
         tick(2);
         chk({freq, nreq}, 32'h2);
         fast_rd = 1'b1;
         tick(1);
         fast_rd = 1'b0;
         tick(1);
         chk(fvec, 32'hf00);
         cfg(5'h0, 5'h00, 32'hf00);
         chk(freq, 32'h0);
         src[0] = 1'b0;
         tick(2);
         chk(freq, 32'h1);
         cmd(2'h1, 32'h1);
         chk(freq, 32'h0);
         $display("t_fast done");
      end
   endtask
   task t_soft;
      begin
         cfg(5'h1, 5'h0b, 32'h100);
         cmd(2'h0, 32'h2);
         cmd(2'h2, 32'h2);
         chk(nreq, 32'h1);
         cmd(2'h3, 32'h2);
         chk(nreq, 32'h0);
         $display("t_soft done");
      end
   endtask
   // ==========================================
   // Main sequence
   // Clock at 40 MHz.
   initial begin
      forever #12.5 sys_clk = ~sys_clk;
   end
   // Reset for three cycles, then each scenario in turn.
   initial begin
      {sys_clk, reset_n, cfg_wr, fast_rd, prot, go, wb, eg} = 8'h0;
      {src, en, dis, sc, cc, cfg_vec, cfg_idx, cfg_mode} = 202'h0;
      spur = 32'hbad0;
      miscompares = 0;
      num_checks = 0;
      tick(3);
      reset_n = 1'b1;
      tick(3);
      t_prio;
      t_nest;
      t_prot;
      t_mask;
      t_fast;
      t_soft;
      complete_run;
   end
endmodule
